/* File: pkg/adc_port_consts.svh */
`ifndef ADC_PORT_CONSTS_SVH
`define ADC_PORT_CONSTS_SVH

// *****************************************************************************
// Frame and command layout.
// *****************************************************************************
`define FRAME_BITS 8
`define CMD_OP_MSB 7
`define CMD_OP_LSB 6
`define CMD_OUT_MSB 3
`define CMD_OUT_LSB 0
`define CMD_MODE_BIT 0
`define CMD_SEL_MSB 1
`define CMD_SEL_LSB 0
`define CFG_RESET 8'h00

// *****************************************************************************
// Conversion timing in oscillator clocks.
// *****************************************************************************
`define INT_CLKS_50HZ 16'h028F
`define INT_CLKS_60HZ 16'h0221
`define DEINT_MAX 16'hFFFF

// *****************************************************************************
// Result buffer.
// *****************************************************************************
`define FIFO_DEPTH 16
`define FIFO_WIDTH 16

`endif

/* File: pkg/adc_port_pkg.sv */
package adc_port_pkg;

  // Command operations carried in the top two bits of a received byte.
  typedef enum logic [1:0] {
    OP_NOP = 2'h0,
    OP_OUTPUTS = 2'h1,
    OP_MODE = 2'h2,
    OP_SELECT = 2'h3
  } cmd_op_t;

  // Conversion sequencer states, Gray coded along the usual path.
  typedef enum logic [1:0] {
    CONV_IDLE = 2'b00,
    CONV_INTEG = 2'b01,
    CONV_DEINT = 2'b11,
    CONV_DONE = 2'b10
  } conv_state_t;

endpackage

/* File: design/sync_stage.sv */
`timescale 1ns/1ps
`include "adc_port_consts.svh"

// Two flip-flop synchroniser for one level; the reset level matches the idle level of the input.
module sync_stage #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Level in and out.
  input wire logic async_in,
  output logic sync_out
);

  logic meta_q;

  // The first stage is read only by the second.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

/* File: design/result_fifo.sv */
`timescale 1ns/1ps
`include "adc_port_consts.svh"

// Synchronous FIFO built of flip-flops, valid/ready on both sides.
module result_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] count_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // Full and empty come straight from the occupancy count.
  assign in_ready = (count_q != DEPTH[AW:0]);
  assign out_valid = (count_q != '0);
  assign out_data = mem_q[rd_q];

  // Storage write.
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Pointers and count.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_q <= '0;
      rd_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      count_q <= count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

endmodule

/* File: design/adc_serial_port.sv */
// Functional notes
// - Serial transfers happen only while chip select is held low.
// - Chip select rising edge moves the input shift byte into a command register.
// - Chip select falling edge puts bit 7 of the held output register on the pin; the shifter loads it on the first shift clock falling edge.
// - Serial data output is released while chip select is high.
// - Input is sampled on shift clock rising edges, bit 7 first.
// - Output changes on shift clock falling edges, bit 7 first, descending.
// - Four user outputs follow the levels last written over the serial port.
// - End-of-conversion goes high when a finished conversion's result is posted to the buffer.
// - Mode bit picks 655 clocks for 50 Hz or 545 clocks for 60 Hz.
// - Integrate for the fixed period, then count deintegration clocks to zero.
`timescale 1ns/1ps
`include "adc_port_consts.svh"

module adc_serial_port (
  // System clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // Serial link, shift clock is its own domain.
  input wire logic link_sclk,
  input wire logic cs_n,
  input wire logic ser_din,
  output logic ser_dout,
  output logic ser_dout_oe,
  // Oscillator-timed conversion inputs and phase outputs.
  input wire logic oscillator_in,
  input wire logic integ_zero,
  output logic integ_phase,
  output logic deint_phase,
  // Status and user outputs.
  output logic eoc,
  output logic line_50hz,
  output logic user_out_0,
  output logic user_out_1,
  output logic user_out_2,
  output logic user_out_3
);
  import adc_port_pkg::*;

  // ***************************************************************************
  // Link domain: shift registers run on the shift clock.
  // ***************************************************************************
  logic [7:0] rx_shift_q;
  logic [2:0] rx_cnt_q;
  logic [7:0] rx_byte_q;
  logic rx_tgl_q;
  logic [7:0] tx_shift_q;
  logic [7:0] tx_hold_q;
  logic dout_q;

  // Receive bits on rising edges while selected, MSB first.
  always_ff @(posedge link_sclk or negedge reset_n) begin
    if (!reset_n) begin
      rx_shift_q <= 8'h00;
      rx_byte_q <= 8'h00;
      rx_tgl_q <= 1'b0;
    end else if (!cs_n) begin
      rx_shift_q <= {rx_shift_q[6:0], ser_din};
      if (rx_cnt_q == 3'h7) begin
        rx_byte_q <= {rx_shift_q[6:0], ser_din};
        rx_tgl_q <= ~rx_tgl_q;
      end
    end
  end

  // The bit counter restarts with every frame, so a cut byte never shifts the next one.
  wire frame_clr = cs_n || !reset_n;
  always_ff @(posedge link_sclk or posedge frame_clr) begin
    if (frame_clr) begin
      rx_cnt_q <= 3'h0;
    end else begin
      rx_cnt_q <= rx_cnt_q + 3'h1;
    end
  end

  // Shift out on falling edges; the shifter loads the hold register on the first falling edge of a frame.
  logic [7:0] tx_load_w;
  always_ff @(negedge link_sclk or posedge cs_n) begin
    if (cs_n) begin
      tx_shift_q <= 8'h00;
    end else if (tx_first_q) begin
      tx_shift_q <= {tx_load_w[6:0], 1'b0};
    end else begin
      tx_shift_q <= {tx_shift_q[6:0], 1'b0};
    end
  end

  // Output driver: bit 7 appears at the falling chip select edge.
  logic tx_first_q;
  always_ff @(negedge link_sclk or posedge cs_n) begin
    if (cs_n) begin
      tx_first_q <= 1'b1;
    end else begin
      tx_first_q <= 1'b0;
    end
  end
  assign tx_load_w = tx_hold_q;
  wire tx_bit = tx_first_q ? tx_load_w[6] : tx_shift_q[6];

  // ***************************************************************************
  // System domain: command decode and output registers.
  // ***************************************************************************
  logic cs_sync;
  logic byte_ok_q;
  logic tgl_sync;
  logic tgl_seen_q;
  logic cs_seen_q;
  logic [7:0] last_byte_q;
  logic [3:0] user_q;
  logic mode_50_q;
  logic [1:0] sel_q;
  logic start_q;

  sync_stage #(.RST_VAL(1'b1)) u_sync_cs (
    .clk(sys_clk),
    .reset_n(reset_n),
    .async_in(cs_n),
    .sync_out(cs_sync)
  );
  sync_stage u_sync_tgl (
    .clk(sys_clk),
    .reset_n(reset_n),
    .async_in(rx_tgl_q),
    .sync_out(tgl_sync)
  );

  // The received byte is stable once its toggle has crossed.
  wire byte_new = tgl_sync ^ tgl_seen_q;
  wire cs_rise = cs_sync && !cs_seen_q;
  wire cs_fall = !cs_sync && cs_seen_q;
  wire [1:0] op_w = byte_ok_q ? last_byte_q[`CMD_OP_MSB:`CMD_OP_LSB] : OP_NOP;

  // Byte capture and command execution at chip select release.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tgl_seen_q <= 1'b0;
      cs_seen_q <= 1'b1;
      last_byte_q <= `CFG_RESET;
      user_q <= 4'h0;
      mode_50_q <= 1'b0;
      sel_q <= 2'h0;
      byte_ok_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      tgl_seen_q <= tgl_sync;
      cs_seen_q <= cs_sync;
      start_q <= 1'b0;
      if (byte_new) begin
        last_byte_q <= rx_byte_q;
        byte_ok_q <= 1'b1;
      end else if (cs_rise) begin
        byte_ok_q <= 1'b0;
      end
      if (cs_rise) begin
        case (op_w)
          OP_OUTPUTS: user_q <= last_byte_q[`CMD_OUT_MSB:`CMD_OUT_LSB];
          OP_MODE: begin
            mode_50_q <= last_byte_q[`CMD_MODE_BIT];
            start_q <= 1'b1;
          end
          OP_SELECT: sel_q <= last_byte_q[`CMD_SEL_MSB:`CMD_SEL_LSB];
          default: start_q <= 1'b0;
        endcase
      end
    end
  end

  // ***************************************************************************
  // Conversion sequencer, timed by the synchronised oscillator.
  // ***************************************************************************
  logic osc_sync;
  logic zero_sync;
  logic osc_prev_q;
  conv_state_t state_q;
  logic [15:0] cnt_q;
  logic eoc_q;
  logic [15:0] res_data;
  logic res_valid;
  logic res_ready;

  sync_stage u_sync_osc (
    .clk(sys_clk),
    .reset_n(reset_n),
    .async_in(oscillator_in),
    .sync_out(osc_sync)
  );
  sync_stage u_sync_zero (
    .clk(sys_clk),
    .reset_n(reset_n),
    .async_in(integ_zero),
    .sync_out(zero_sync)
  );

  wire osc_tick = osc_sync && !osc_prev_q;
  wire [15:0] int_len = mode_50_q ? `INT_CLKS_50HZ : `INT_CLKS_60HZ;
  wire fifo_in_ready;
  wire push_res = (state_q == CONV_DONE) && fifo_in_ready;

  // Integrate, deintegrate, then post the count; full buffer stalls here.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_prev_q <= 1'b0;
      state_q <= CONV_IDLE;
      cnt_q <= 16'h0000;
      eoc_q <= 1'b0;
    end else begin
      osc_prev_q <= osc_sync;
      case (state_q)
        CONV_IDLE: begin
          if (start_q) begin
            state_q <= CONV_INTEG;
            cnt_q <= 16'h0000;
            eoc_q <= 1'b0;
          end
        end
        CONV_INTEG: begin
          if (osc_tick) begin
            if (cnt_q == int_len - 16'h0001) begin
              state_q <= CONV_DEINT;
              cnt_q <= 16'h0000;
            end else begin
              cnt_q <= cnt_q + 16'h0001;
            end
          end
        end
        CONV_DEINT: begin
          if (zero_sync || cnt_q == `DEINT_MAX) begin
            state_q <= CONV_DONE;
          end else if (osc_tick) begin
            cnt_q <= cnt_q + 16'h0001;
          end
        end
        CONV_DONE: begin
          if (push_res) begin
            state_q <= CONV_IDLE;
            eoc_q <= 1'b1;
          end
        end
        default: state_q <= CONV_IDLE;
      endcase
    end
  end

  result_fifo #(
    .WIDTH(`FIFO_WIDTH),
    .DEPTH(`FIFO_DEPTH)
  ) u_fifo (
    .clk(sys_clk),
    .reset_n(reset_n),
    .in_valid(state_q == CONV_DONE),
    .in_ready(fifo_in_ready),
    .in_data(cnt_q),
    .out_valid(res_valid),
    .out_ready(res_ready),
    .out_data(res_data)
  );

  // Output register selection; a result is popped when chip select falls with sel_q 0 or 1.
  assign res_ready = cs_fall && !sel_q[1];
  wire [7:0] out_sel = (sel_q == 2'h0) ? res_data[15:8] :
                       (sel_q == 2'h1) ? res_data[7:0] :
                       (sel_q == 2'h2) ? {4'h0, res_valid, eoc_q, mode_50_q, 1'b0} :
                       {4'h0, user_q};

  // Hold register stays stable while the synchronised chip select (cs_sync) is low.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_hold_q <= 8'h00;
    end else if (cs_sync) begin
      tx_hold_q <= out_sel;
    end
  end

  // ***************************************************************************
  // Output flops.
  // ***************************************************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      eoc <= 1'b0;
      line_50hz <= 1'b0;
      integ_phase <= 1'b0;
      deint_phase <= 1'b0;
      {user_out_3, user_out_2, user_out_1, user_out_0} <= 4'h0;
    end else begin
      eoc <= eoc_q;
      line_50hz <= mode_50_q;
      integ_phase <= (state_q == CONV_INTEG);
      deint_phase <= (state_q == CONV_DEINT);
      {user_out_3, user_out_2, user_out_1, user_out_0} <= user_q;
    end
  end

  // Data pin flops on the link side; released while deselected.
  always_ff @(negedge link_sclk or posedge cs_n) begin
    if (cs_n) begin
      dout_q <= 1'b0;
    end else begin
      dout_q <= tx_bit;
    end
  end
  assign ser_dout_oe = !cs_n;
  assign ser_dout = tx_first_q ? tx_hold_q[7] : dout_q;

  // ***************************************************************************
  // Checks.
  // ***************************************************************************
  chk_oe_release: assert property (@(posedge sys_clk) disable iff (!reset_n)
    cs_n |-> !ser_dout_oe) else $error("data pin driven while deselected");
  chk_user_follow: assert property (@(posedge sys_clk) disable iff (!reset_n)
    cs_rise && op_w == OP_OUTPUTS |-> ##2 user_out_0 == $past(last_byte_q[0], 2))
    else $error("user output not updated");
  chk_eoc_high: assert property (@(posedge sys_clk) disable iff (!reset_n)
    push_res |-> ##2 eoc) else $error("end of conversion not raised");
  chk_integ_len: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state_q == CONV_INTEG |-> cnt_q < int_len) else $error("integration overran");
  chk_deint_follow: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state_q == CONV_INTEG && osc_tick && cnt_q == int_len - 16'h0001 |=> state_q == CONV_DEINT)
    else $error("deintegration did not follow");
  chk_cmd_only_rise: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !cs_rise |=> $stable(mode_50_q)) else $error("mode changed outside frame end");
  chk_hold_stable: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !cs_sync |=> $stable(tx_hold_q)) else $error("output byte changed in frame");
  chk_rx_mode: assert property (@(posedge sys_clk) disable iff (!reset_n)
    cs_rise && op_w == OP_MODE |=> mode_50_q == $past(last_byte_q[0]))
    else $error("mode bit not taken");

endmodule

/* File: dv/host_link_model.sv */
`timescale 1ns/1ps

// Host side of the link: bytes go out MSB first, shift clock runs only in frames.
module host_link_model (
  // Link lines driven by the host.
  output logic link_sclk,
  output logic cs_n,
  output logic ser_din,
  // Serial data from the device.
  input wire logic ser_dout,
  input wire logic ser_dout_oe
);
  // Idle lines at time zero.
  initial begin
    link_sclk = 1'b0;
    cs_n = 1'b1;
    ser_din = 1'b1;
  end

  // One frame of nbits, 32 ns shift clock, then 1 us of chip select high.
  task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    #3;
    cs_n = 1'b0;
    ser_din = tx[7];
    #40;
    for (int i = 7; i > 7 - nbits; i--) begin
      // A released output reads as unknown so it can never match.
      rx[i] = ser_dout_oe ? ser_dout : 1'bx;
      link_sclk = 1'b1;
      #16;
      link_sclk = 1'b0;
      if (i > 0) begin
        ser_din = tx[i-1];
      end else begin
        ser_din = ~ser_din;
      end
      #16;
    end
    cs_n = 1'b1;
    ser_din = ~ser_din; // The released line does not keep its last level.
    #1000;
  endtask
endmodule

/* File: dv/adc_serial_port_tb.sv */
`timescale 1ns/1ps
`include "adc_port_consts.svh"

module adc_serial_port_tb;
  import adc_port_pkg::*;
  // ********
  // Signals.
  // ********
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic oscillator_in = 1'b0;
  logic integ_zero = 1'b0;
  logic osc_run = 1'b0;
  int osc_cnt = 0;
  logic link_sclk, cs_n, ser_din, ser_dout, ser_dout_oe;
  logic integ_phase, deint_phase, eoc, line_50hz;
  logic user_out_0, user_out_1, user_out_2, user_out_3;
  logic [3:0] user;
  logic [7:0] rx;
  int fails = 0;
  int n_tests = 0;

  assign user = {user_out_3, user_out_2, user_out_1, user_out_0};

  // System clock of 8 ns.
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end

  // Oscillator of six system clocks, stopped while osc_run is low.
  always @(negedge sys_clk) begin
    osc_cnt <= osc_run ? (osc_cnt + 1) % 6 : 0;
    oscillator_in <= osc_run && (osc_cnt < 3);
  end

  adc_serial_port dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .link_sclk(link_sclk), .cs_n(cs_n),
    .ser_din(ser_din), .ser_dout(ser_dout), .ser_dout_oe(ser_dout_oe),
    .oscillator_in(oscillator_in), .integ_zero(integ_zero), .integ_phase(integ_phase),
    .deint_phase(deint_phase), .eoc(eoc), .line_50hz(line_50hz), .user_out_0(user_out_0),
    .user_out_1(user_out_1), .user_out_2(user_out_2), .user_out_3(user_out_3)
  );

  host_link_model host (
    .link_sclk(link_sclk), .cs_n(cs_n), .ser_din(ser_din),
    .ser_dout(ser_dout), .ser_dout_oe(ser_dout_oe)
  );

  // ********
  // Checking.
  // ********
  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    if (fails == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Waits a bounded time for a level; running out counts as a mismatch.
  task automatic wait_for(ref logic sig, input logic lvl);
    int n;
    n = 0;
    while (sig !== lvl && n < 20000) begin
      @(negedge sys_clk);
      n++;
    end
    chk_bit("wait level", lvl, sig);
  endtask

  // ********
  // Scenarios.
  // ********
  // Everything is low and the output released under reset.
  task automatic t_reset();
    repeat (4) @(negedge sys_clk);
    chk_val("reset outs", 16'h0000, {ser_dout_oe, eoc, line_50hz, integ_phase, deint_phase, user});
    reset_n = 1'b1;
    repeat (3) @(negedge sys_clk);
  endtask

  // User pins follow whole output commands only, then read back.
  task automatic t_user();
    logic [3:0] vals [4] = '{4'hA, 4'h0, 4'hF, 4'h5};
    foreach (vals[i]) begin
      host.xfer({OP_OUTPUTS, 2'b00, vals[i]}, 8, rx);
      chk_val("user pins", {12'h000, vals[i]}, {12'h000, user});
    end
    host.xfer({OP_OUTPUTS, 6'h0F}, 4, rx);
    chk_val("partial byte", 16'h0005, {12'h000, user});
    host.xfer({OP_NOP, 6'h0F}, 8, rx);
    chk_val("no-op byte", 16'h0005, {12'h000, user});
    host.xfer({OP_OUTPUTS, 6'h06}, 8, rx);
    host.xfer({OP_SELECT, 6'h03}, 8, rx);
    host.xfer({OP_NOP, 6'h00}, 8, rx);
    chk_val("user readback", 16'h0006, {8'h00, rx});
    chk_bit("released", 1'b0, ser_dout_oe);
  endtask

  // One conversion: integrate for the mode's count, deintegrate k clocks.
  // With stall set the buffer is full, so the result must wait and eoc stay low.
  task automatic t_conv(input logic mode, input int k, input bit stall);
    int n;
    host.xfer({OP_MODE, 5'h00, mode}, 8, rx);
    wait_for(integ_phase, 1'b1);
    chk_bit("eoc cleared", 1'b0, eoc);
    chk_bit("line_50hz", mode, line_50hz);
    @(posedge sys_clk);
    osc_run = 1'b1;
    n = 0;
    @(posedge oscillator_in);
    while (integ_phase === 1'b1 && n < 1000) begin
      n++;
      @(posedge oscillator_in);
    end
    chk_val("integ clocks", mode ? `INT_CLKS_50HZ : `INT_CLKS_60HZ, n[15:0]);
    chk_bit("deint start", 1'b1, deint_phase);
    repeat (k) @(posedge oscillator_in);
    chk_bit("deint held", 1'b1, deint_phase);
    @(negedge sys_clk);
    integ_zero = 1'b1;
    if (stall) begin
      repeat (20) @(negedge sys_clk);
      chk_bit("eoc while full", 1'b0, eoc);
    end else begin
      wait_for(eoc, 1'b1);
    end
    chk_bit("deint end", 1'b0, deint_phase);
    @(posedge sys_clk);
    osc_run = 1'b0;
    @(negedge sys_clk);
    integ_zero = 1'b0;
  endtask

  // Seventeen results against a 16-deep buffer, then drain it empty.
  task automatic t_fifo();
    for (int i = 0; i < 16; i++) begin
      t_conv(~i[0], (i == 0) ? 16'h0123 : 2, 1'b0);
    end
    t_conv(1'b1, 2, 1'b1);
    host.xfer({OP_SELECT, 6'h02}, 8, rx);
    host.xfer({OP_NOP, 6'h00}, 8, rx);
    chk_val("status full", 16'h000A, {8'h00, rx});
    host.xfer({OP_SELECT, 6'h00}, 8, rx);
    host.xfer({OP_NOP, 6'h00}, 8, rx);
    chk_val("first result hi", 16'h0001, {8'h00, rx});
    chk_bit("eoc after drain", 1'b1, eoc);
    repeat (15) host.xfer({OP_NOP, 6'h00}, 8, rx);
    host.xfer({OP_SELECT, 6'h02}, 8, rx);
    host.xfer({OP_NOP, 6'h00}, 8, rx);
    chk_val("status empty", 16'h0006, {8'h00, rx});
  endtask

  // Main sequence.
  initial begin
    t_reset();
    t_user();
    t_fifo();
    conclude();
  end

  // Cuts a hang short well past the expected run time.
  initial begin
    #750_000;
    fails++;
    conclude();
  end
endmodule
